/* File: rtl/rtp_pkg.sv */
package rtp_pkg;
	localparam int DW_W     = 32;
	localparam int LANES    = 4;
	localparam int DATA_W   = 128;
	localparam int USER_W   = 22;
	localparam int SOF_LSB  = 10;
	localparam int EOF_LSB  = 17;
	localparam int DEPTH_DW = 2048;
	localparam int ADDR_W   = 11;
	localparam int PTR_W    = 12;
	localparam int ROW_W    = 9;
	localparam int ENT_W    = 33;

	localparam logic [4:0]       SOF_AT_DW0  = 5'h10;
	localparam logic [4:0]       SOF_AT_DW2  = 5'h18;
	localparam logic [4:0]       MARK_NONE   = 5'h00;
	localparam logic [1:0]       EOF_BYTE_LO = 2'h3;
	localparam logic [2:0]       TAKE_FULL   = 3'h4;
	localparam logic [PTR_W-1:0] PTR_RST     = 12'h000;
	localparam logic [PTR_W-1:0] PTR_ONE     = 12'h001;
	localparam logic [PTR_W-1:0] DEPTH_PTR   = 12'h800;

	typedef logic [ENT_W-1:0] rtp_entry_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BODY = 2'b10
	} rtp_state_t;
endpackage

/* File: rtl/rtp_store_if.sv */
`timescale 1ns/1ps
interface rtp_store_if;
	import rtp_pkg::*;
	logic                    wrEn;
	logic [ADDR_W-1:0]       wrAddr;
	rtp_entry_t              wrData;
	logic [PTR_W-1:0]        pktCnt;
	logic [PTR_W-1:0]        rdPtr;
	logic                    pktTaken;

	modport track (output wrEn, output wrAddr, output wrData, output pktCnt,
		input rdPtr, input pktTaken);
	modport bank (input wrEn, input wrAddr, input wrData);
	modport frame (input pktCnt, output rdPtr, output pktTaken);
endinterface

/* File: rtl/rtp_dw_bank.sv */
`timescale 1ns/1ps
module rtp_dw_bank #(
	parameter logic [1:0] BANK = 2'h0
) (
	input  logic                      clk,
	input  logic                      nrst,
	input  logic                      ce,
	input  logic [rtp_pkg::ROW_W-1:0] rdRow,
	output rtp_pkg::rtp_entry_t       rdData,
	rtp_store_if.bank                 st
);
	import rtp_pkg::*;

	rtp_entry_t        mem [0:(1 << ROW_W)-1];
	rtp_entry_t        rdData_q;
	logic              wrHere;
	logic [ROW_W-1:0]  wrRow;

	assign wrHere = st.wrEn && (st.wrAddr[1:0] == BANK);
	assign wrRow  = st.wrAddr[ADDR_W-1:2];
	assign rdData = rdData_q;

	always_ff @(posedge clk) begin
		if (ce && wrHere) begin
			mem[wrRow] <= st.wrData;
		end
	end

	// write-through so a word stored this edge is seen at once
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdData_q <= '0;
		end else if (ce) begin
			rdData_q <= (wrHere && (wrRow == rdRow)) ? st.wrData : mem[rdRow];
		end
	end
endmodule

/* File: rtl/rtp_fill_track.sv */
`timescale 1ns/1ps
module rtp_fill_track (
	input  logic                     clk,
	input  logic                     nrst,
	input  logic                     ce,
	input  logic [rtp_pkg::DW_W-1:0] srcDword,
	input  logic                     srcValid,
	input  logic                     srcLast,
	output logic                     srcReady,
	rtp_store_if.track               st
);
	import rtp_pkg::*;

	logic [PTR_W-1:0] wrPtr_q;
	logic [PTR_W-1:0] wrPtr_d;
	logic [PTR_W-1:0] pktCnt_q;
	logic [PTR_W-1:0] pktCnt_d;
	logic [PTR_W-1:0] used;
	logic             ready_q;
	logic             push;

	assign push     = ce && srcValid && ready_q;
	assign wrPtr_d  = push ? wrPtr_q + PTR_ONE : wrPtr_q;
	// read pointer taken before this edge's move: space is never overstated
	assign used     = wrPtr_d - st.rdPtr;
	assign pktCnt_d = pktCnt_q + ((push && srcLast) ? PTR_ONE : PTR_RST)
		- (st.pktTaken ? PTR_ONE : PTR_RST);

	assign st.wrEn   = push;
	assign st.wrAddr = wrPtr_q[ADDR_W-1:0];
	assign st.wrData = {srcLast, srcDword};
	assign st.pktCnt = pktCnt_q;
	assign srcReady  = ready_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_q  <= PTR_RST;
			pktCnt_q <= PTR_RST;
			ready_q  <= 1'b0;
		end else if (ce) begin
			wrPtr_q  <= wrPtr_d;
			pktCnt_q <= pktCnt_d;
			ready_q  <= (used < DEPTH_PTR);
		end
	end
endmodule

/* File: rtl/rtp_rx_framer.sv */
`timescale 1ns/1ps
module rtp_rx_framer (
	input  logic                       clk,
	input  logic                       nrst,
	input  logic                       ce,
	input  logic [rtp_pkg::DW_W-1:0]   srcDword,
	input  logic                       srcValid,
	input  logic                       srcLast,
	output logic                       srcReady,
	output logic [rtp_pkg::DATA_W-1:0] m_axis_rx_tdata,
	output logic                       m_axis_rx_tvalid,
	input  logic                       m_axis_rx_tready,
	output logic [rtp_pkg::USER_W-1:0] m_axis_rx_tuser
);
	import rtp_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// storage

	rtp_store_if st ();

	rtp_fill_track uTrack (
		.clk      (clk),
		.nrst     (nrst),
		.ce       (ce),
		.srcDword (srcDword),
		.srcValid (srcValid),
		.srcLast  (srcLast),
		.srcReady (srcReady),
		.st       (st)
	);

	logic [PTR_W-1:0]  rdPtr_q;
	logic [PTR_W-1:0]  rdPtr_d;
	logic [ROW_W-1:0]  rdRow    [LANES];
	rtp_entry_t        bankData [LANES];
	logic [DW_W-1:0]   laneDw   [LANES];
	logic [LANES-1:0]  laneLast;

	genvar gi;
	generate
		for (gi = 0; gi < LANES; gi++) begin : gBank
			// banks below the start bank serve the following row
			assign rdRow[gi] = rdPtr_d[ADDR_W-1:2]
				+ ROW_W'(2'(gi) < rdPtr_d[1:0]);

			rtp_dw_bank #(
				.BANK (2'(gi))
			) uBank (
				.clk    (clk),
				.nrst   (nrst),
				.ce     (ce),
				.rdRow  (rdRow[gi]),
				.rdData (bankData[gi]),
				.st     (st)
			);

			// lane 0 is always the DWORD at the read pointer
			assign laneDw[gi]   = bankData[2'(rdPtr_q[1:0] + 2'(gi))][DW_W-1:0];
			assign laneLast[gi] = bankData[2'(rdPtr_q[1:0] + 2'(gi))][DW_W];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// decoding helpers

	// lowest lane holding a packet's last DWORD: {found, index}
	function automatic logic [2:0] findLast(input logic [LANES-1:0] lastBits);
		logic [2:0] res;
		res = 3'h0;
		for (int j = LANES - 1; j >= 0; j--) begin
			if (lastBits[j]) begin
				res = {1'b1, 2'(j)};
			end
		end
		return res;
	endfunction

	function automatic logic [4:0] endCode(input logic [1:0] dwIdx);
		return {1'b1, dwIdx, EOF_BYTE_LO};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// beat builder

	rtp_state_t         state_q;
	rtp_state_t         state_d;
	logic               load;
	logic               pktAvail;
	logic [2:0]         hit;
	logic               beatValid;
	logic [DATA_W-1:0]  beatData;
	logic [4:0]         sofCode;
	logic [4:0]         eofCode;
	logic [2:0]         take;
	logic               starts;

	// a packet is started only once it is stored whole, so valid never gaps
	assign pktAvail = (st.pktCnt != PTR_RST);
	assign hit      = findLast(laneLast);
	// new beat only after the held one is accepted
	assign load     = ce && (!m_axis_rx_tvalid || m_axis_rx_tready);

	always_comb begin
		beatValid = 1'b0;
		beatData  = '0;
		sofCode   = MARK_NONE;
		eofCode   = MARK_NONE;
		take      = 3'h0;
		starts    = 1'b0;
		state_d   = state_q;
		case (state_q)
			ST_IDLE: begin
				if (pktAvail) begin
					beatValid = 1'b1;
					starts    = 1'b1;
					sofCode   = SOF_AT_DW0;
					for (int j = 0; j < LANES; j++) begin
						if (!hit[2] || (2'(j) <= hit[1:0])) begin
							beatData[j*DW_W +: DW_W] = laneDw[j];
						end
					end
					if (hit[2]) begin
						eofCode = endCode(hit[1:0]);
						take    = 3'(hit[1:0]) + 3'h1;
					end else begin
						take    = TAKE_FULL;
						state_d = ST_BODY;
					end
				end
			end
			ST_BODY: begin
				beatValid = 1'b1;
				for (int j = 0; j < LANES; j++) begin
					if (!hit[2] || (2'(j) <= hit[1:0])) begin
						beatData[j*DW_W +: DW_W] = laneDw[j];
					end
				end
				if (!hit[2]) begin
					take = TAKE_FULL;
				end else begin
					eofCode = endCode(hit[1:0]);
					take    = 3'(hit[1:0]) + 3'h1;
					state_d = ST_IDLE;
					// straddle: next packet fills the upper QWORD; receive path only
					if (!hit[1] && pktAvail) begin
						sofCode = SOF_AT_DW2;
						starts  = 1'b1;
						take    = 3'(hit[1:0]) + 3'h3;
						state_d = ST_BODY;
						beatData[2*DW_W +: DW_W] = laneDw[2'(hit[1:0] + 2'h1)];
						beatData[3*DW_W +: DW_W] = laneDw[2'(hit[1:0] + 2'h2)];
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	assign rdPtr_d     = (load && beatValid) ? rdPtr_q + PTR_W'(take) : rdPtr_q;
	assign st.rdPtr    = rdPtr_q;
	assign st.pktTaken = load && beatValid && starts;

	////////////////////////////////////////////////////////////////////////////////
	// state and output registers

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
		end else if (load) begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdPtr_q <= PTR_RST;
		end else if (ce) begin
			rdPtr_q <= rdPtr_d;
		end
	end

	// held unchanged while the consumer stalls
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			m_axis_rx_tvalid <= 1'b0;
			m_axis_rx_tdata  <= '0;
			m_axis_rx_tuser  <= '0;
		end else if (load) begin
			m_axis_rx_tvalid <= beatValid;
			m_axis_rx_tdata  <= beatData;
			m_axis_rx_tuser  <= '0;
			m_axis_rx_tuser[SOF_LSB +: 5] <= sofCode;
			m_axis_rx_tuser[EOF_LSB +: 5] <= eofCode;
		end
	end
endmodule

/* File: bench/rtp_rx_framer_props.sv */
`timescale 1ns/1ps
module rtp_rx_framer_props (
	input logic                       clk,
	input logic                       nrst,
	input logic                       ce,
	input logic [rtp_pkg::DATA_W-1:0] m_axis_rx_tdata,
	input logic                       m_axis_rx_tvalid,
	input logic                       m_axis_rx_tready,
	input logic [rtp_pkg::USER_W-1:0] m_axis_rx_tuser
);
	import rtp_pkg::*;
	logic       v, r, inPkt_q;
	logic [4:0] s, e;
	assign v = m_axis_rx_tvalid;
	assign r = m_axis_rx_tready;
	assign s = m_axis_rx_tuser[14:10];
	assign e = m_axis_rx_tuser[21:17];
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////
	// open packet tracker
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			inPkt_q <= 1'b0;
		else if (ce && v && r)
			inPkt_q <= s[4] ? (s[3] || !e[4]) : !e[4];
	end
	////////////////////////////////////////////////////////////////
	a_stall_hold:
	assert property (v && !r |=> v && $stable(m_axis_rx_tdata) && $stable(m_axis_rx_tuser))
		else $error("beat changed while stalled");
	a_no_mid_drop:
	assert property (v && r && !e[4] |=> v) else $error("valid dropped mid packet");
	a_start_code:
	assert property (v && s[4] |-> s[3:0] == 4'h0 || s[3:0] == 4'h8) else $error("bad start code");
	a_end_code:
	assert property (v && e[4] |-> e[1:0] == EOF_BYTE_LO) else $error("bad end code");
	a_idle_start_zero:
	assert property (v && !s[4] |-> s == MARK_NONE) else $error("start bits without flag");
	a_straddle_pair:
	assert property (v && s == SOF_AT_DW2 |-> e[4] && !e[3]) else $error("bad straddle beat");
	a_gap_starts:
	assert property (v && !inPkt_q |-> s[4]) else $error("beat outside packet lacks start");
	a_one_start:
	assert property (v && inPkt_q && s[4] |-> s[3] && e[4]) else $error("second start in packet");
	a_single_beat:
	assert property (v && s == SOF_AT_DW0 && e[4] |-> e[3]) else $error("short single beat");
	a_tail_zero:
	assert property (v && e[4] && !s[4] && e[3:2] == 2'h0 |-> m_axis_rx_tdata[127:32] == '0)
		else $error("unused dwords not zero");
endmodule

/* File: bench/rtp_sink_model.sv */
`timescale 1ns/1ps
module rtp_sink_model (
	input  logic clk,
	input  logic nrst,
	input  logic hold,
	input  logic slow,
	output logic tready
);
	logic tog_q;
	// slow consumer stalls every other cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			tog_q <= 1'b0;
		else
			tog_q <= !tog_q;
	end
	assign tready = !hold && (!slow || tog_q);
endmodule

/* File: bench/rx_tlp_stream_128b_tb.sv */
`timescale 1ns/1ps
module rx_tlp_stream_128b_tb;
	import rtp_pkg::*;
	logic              clk = 0, nrst = 1, ce = 1, srcValid = 0, srcLast = 0, hold = 1, slow = 0;
	logic [DW_W-1:0]   srcDword = '0;
	logic              srcReady, tvalid, tready;
	logic [DATA_W-1:0] tdata, bd = '0;
	logic [USER_W-1:0] tuser, bu = '0;
	int                n_mismatch = 0, cmp_count = 0, pos = 0, w;
	logic [149:0]      expQ[$];
	int                lens[8] = '{3, 4, 6, 5, 3, 7, 8, 3};
	always #10 clk = !clk;
	rtp_rx_framer DUT (.clk(clk), .nrst(nrst), .ce(ce), .srcDword(srcDword),
		.srcValid(srcValid), .srcLast(srcLast), .srcReady(srcReady),
		.m_axis_rx_tdata(tdata), .m_axis_rx_tvalid(tvalid),
		.m_axis_rx_tready(tready), .m_axis_rx_tuser(tuser));
	rtp_sink_model SINK (.clk(clk), .nrst(nrst), .hold(hold), .slow(slow), .tready(tready));
	task automatic check(string what, logic [149:0] exp, logic [149:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic conclude;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic flush;
		if (pos > 0)
			expQ.push_back({bd, bu});
		bd = '0;
		bu = '0;
		pos = 0;
	endtask
	////////////////////////////////////////////////////////////////
	// sends one packet and builds its expected beats
	task automatic push(int len, logic [7:0] id);
		if (pos > 2)
			flush;
		if (pos > 0)
			pos = 2;
		bu[14:10] = pos ? SOF_AT_DW2 : SOF_AT_DW0;
		for (int k = 0; k < len; k++) begin
			srcValid = 1;
			srcDword = {id, 24'(k)};
			srcLast = (k == len - 1);
			for (w = 0; w < 50 && srcReady !== 1'b1; w++) @(posedge clk) #1;
			if (w == 50) begin
				n_mismatch++;
				conclude;
			end
			@(posedge clk) #1;
			bd[32*pos+:32] = srcDword;
			pos++;
			if (srcLast)
				bu[21:17] = {1'b1, 2'(pos - 1), EOF_BYTE_LO};
			if (pos == 4)
				flush;
		end
	endtask
	task automatic drain;
		// source released only here, so pushes in a row keep valid high
		srcValid = 0;
		srcLast = 0;
		repeat (4) @(posedge clk) #1;
		check("held start", {1'b1, SOF_AT_DW0}, {tvalid, tuser[14:10]});
		hold = 0;
		for (w = 0; w < 300 && (expQ.size() || tvalid); w++) @(posedge clk) #1;
		if (w == 300)
			n_mismatch++;
		check("drained", 1'b0, tvalid);
		check("beats left", '0, 150'(expQ.size()));
	endtask
	always @(posedge clk) begin
		if (nrst && ce && tvalid && tready) begin
			if (expQ.size() == 0)
				check("extra beat", '0, {tdata, tuser});
			else
				check("beat", expQ.pop_front(), {tdata, tuser});
		end
	end
	initial begin
		// reset edge made at run time so the asynchronous branches fire
		#1 nrst = 0;
		#14 check("reset outputs", '0, {srcReady, tvalid, tuser});
		@(posedge clk) #1;
		nrst = 1;
		@(posedge clk) #1;
		foreach (lens[i]) push(lens[i], 8'(i));
		flush;
		drain;
		slow = 1;
		hold = 1;
		push(6, 8'ha0);
		push(3, 8'ha1);
		push(5, 8'ha2);
		flush;
		drain;
		conclude;
	end
endmodule
bind rtp_rx_framer rtp_rx_framer_props P (.clk(clk), .nrst(nrst), .ce(ce),
	.m_axis_rx_tdata(m_axis_rx_tdata), .m_axis_rx_tvalid(m_axis_rx_tvalid),
	.m_axis_rx_tready(m_axis_rx_tready), .m_axis_rx_tuser(m_axis_rx_tuser));
